// ### verif/sem_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// encoder at the far end of the link
// ----------------------------------------
module sem_enc_model (
  input wire logic clk_in,
  input wire logic mdata_in,
  input wire logic oe_in,
  input wire logic comp_in,
  input wire logic mute_in,
  input wire logic [79:0] word_in,
  output logic [15:0] heard_out,
  output wire logic line_out
);
  logic [79:0] sr = '0;
  logic [15:0] h = '0;
  logic drv = 1'b0;
  int n = 0;
  realtime last = 0;
  // enable as it stood just before each clock edge
  wire logic oe_d;
  assign heard_out = h;
  assign #1 oe_d = oe_in;
  assign line_out = oe_in ? mdata_in : drv;
  // gap over 1 us marks a new frame; needs encoder clock of 500 kHz or more
  always @(clk_in) begin
    if ($realtime - last > 1000) begin
      n = 0;
      drv = 1'b0;
    end
    last = $realtime;
    if (clk_in && oe_d) h = {h[14:0], mdata_in};
    if (clk_in == comp_in && !oe_d) begin
      n = n + 1;
      if (n == 3) sr = word_in;
      // start bit, then msb first; past the word it shows inverted bits, not stale ones
      if (n == 3) drv = !mute_in;
      else if (n > 3 && !mute_in) begin
        drv = sr[79];
        sr = {sr[78:0], ~sr[79]};
      end
    end
  end
endmodule // sem_enc_model
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import sem_pkg::*; ;
  logic clock_in = 0, rstn_in = 0, link_clk_in = 0, cfg_wr_in = 0, cfg_newver_in = 0, cfg_delay_comp_in = 0;
  logic cfg_short_rec_in = 0, cfg_short_calc_in = 0, cfg_incr_in = 0, ring_wr_in = 0, trigger_in = 0;
  logic snap_cmd_in = 0, err_clr_in = 0, enc_data_in, pos_valid_out, snap_done_out, busy_out, timeout_err_out;
  logic cfg_reject_out, enc_clk_out, enc_data_out, enc_data_oe_out, mute = 0;
  logic [22:0] cfg_freq_in = '0;
  logic [1:0] op_mode_in = '0, add_mode_in = '0, fixed_sel_in = '0;
  logic [3:0] ring_addr_in = '0;
  logic [7:0] ring_data_in = '0;
  logic [7:0] ring [10];
  logic [31:0] inc_count_in = '0, snap_inc_out;
  logic [47:0] position_out, snap_pos_out;
  logic [15:0] add1_out, add2_out, heard;
  logic [79:0] word = '0;
  int err_count = 0, checks_done = 0, cyc = 0, tcyc, dummy;
  int fr [8] = '{100000, 300000, 500000, 1000000, 2000000, 4000000, 5000000, 6666666};
  realtime tf = 0, hp = 0;
  sem_master #(.CALC_LONG_CYC(2000)) uut (.clock_in, .rstn_in, .link_clk_in, .cfg_wr_in, .cfg_freq_in,
    .cfg_newver_in, .cfg_delay_comp_in, .cfg_short_rec_in, .cfg_short_calc_in, .cfg_incr_in, .op_mode_in,
    .add_mode_in, .fixed_sel_in, .ring_wr_in, .ring_addr_in, .ring_data_in, .trigger_in, .snap_cmd_in,
    .inc_count_in, .err_clr_in, .enc_data_in, .position_out, .add1_out, .add2_out, .pos_valid_out, .snap_pos_out,
    .snap_inc_out, .snap_done_out, .busy_out, .timeout_err_out, .cfg_reject_out, .enc_clk_out, .enc_data_out,
    .enc_data_oe_out);
  sem_enc_model enc (.clk_in(enc_clk_out), .mdata_in(enc_data_out), .oe_in(enc_data_oe_out),
    .comp_in(cfg_delay_comp_in), .mute_in(mute), .word_in(word), .heard_out(heard), .line_out(enc_data_in));
  initial forever #5 clock_in = ~clock_in;
  initial begin
    #3.3;
    forever #7.5 link_clk_in = ~link_clk_in;
  end
  always @(negedge enc_clk_out) tf = $realtime;
  always @(posedge enc_clk_out) hp = $realtime - tf;
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 95000) begin
      err_count++;
      end_sim();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic int exp_hp(int f);
    return (66666666 / (2 * f)) * 15;
  endfunction
  task automatic chk(string s, logic [79:0] e, logic [79:0] g);
    checks_done++;
    if (e !== g) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic cfg(int f, logic nv, logic cp, logic sr, logic sc, logic ic);
    @(negedge clock_in);
    {cfg_freq_in, cfg_newver_in, cfg_delay_comp_in, cfg_short_rec_in, cfg_short_calc_in} = {23'(f), nv, cp, sr, sc};
    cfg_incr_in = ic;
    cfg_wr_in = 1;
    @(negedge clock_in);
    cfg_wr_in = 0;
  endtask
  task automatic poll(logic s);
    word = {$urandom(), $urandom(), 16'($urandom())};
    inc_count_in = $urandom();
    @(negedge clock_in);
    {trigger_in, snap_cmd_in} = {!s, s};
    @(negedge clock_in);
    {trigger_in, snap_cmd_in} = 2'h0;
    chk("busy", 1, busy_out);
    tcyc = 1;
    while (!(pos_valid_out === 1 || snap_done_out === 1 || timeout_err_out === 1) && tcyc < 20000) begin
      @(negedge clock_in);
      tcyc++;
    end
    if (tcyc >= 20000) chk("poll end", 0, 1);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    dummy = $urandom(61);
    repeat (8) @(negedge clock_in);
    rstn_in = 1;
    repeat (4) @(negedge clock_in);
    foreach (fr[i]) begin
      cfg(fr[i], 1, 1, 0, 0, 0);
      chk("reject", 0, cfg_reject_out);
    end
    cfg(0, 1, 0, 1, 0, 0);
    poll(0);
    chk("position", word[79:32], position_out);
    chk("cmd", 6'h02, heard[5:0]);
    chk("half period", exp_hp(2000000), int'(hp));
    cfg(123456, 1, 0, 1, 0, 0);
    chk("reject", 1, cfg_reject_out);
    poll(0);
    chk("half period", exp_hp(2000000), int'(hp));
    cfg(1000000, 0, 0, 0, 0, 0);
    poll(0);
    chk("cmd", 6'h01, heard[5:0]);
    chk("half period", exp_hp(1000000), int'(hp));
    cfg(4000000, 1, 1, 1, 0, 1);
    poll(1);
    chk("snap pos", word[79:32], snap_pos_out);
    chk("snap inc", inc_count_in, snap_inc_out);
    chk("cmd", 6'h01, heard[5:0]);
    cfg(6666666, 1, 1, 1, 0, 0);
    {add_mode_in, fixed_sel_in} = 4'h5;
    @(negedge clock_in);
    {op_mode_in, add_mode_in} = 4'h8;
    poll(0);
    chk("cmd", 6'h03, heard[5:0]);
    chk("add1", word[31:16], add1_out);
    {op_mode_in, add_mode_in, fixed_sel_in} = 6'h08;
    for (int i = 0; i < 11; i++) begin
      ring_addr_in = 4'(i);
      ring_data_in = $urandom();
      if (i < 10) ring[i] = ring_data_in;
      ring_wr_in = 1;
      @(negedge clock_in);
    end
    ring_wr_in = 0;
    for (int i = 0; i < 11; i++) begin
      op_mode_in = 2'(1 + i % 3);
      poll(0);
      chk("supplement", ring[i % 10], heard[7:0]);
      chk("cmd", 6'h03, heard[13:8]);
      chk("add2", word[15:0], add2_out);
    end
    op_mode_in = 0;
    mute = 1;
    for (int k = 0; k < 2; k++) begin
      cfg(6666666, 1, 1, 1, k == 0, 0);
      // let the link finish its recovery so the wait starts at once
      repeat (300) @(negedge clock_in);
      poll(0);
      chk("timeout", 1, timeout_err_out);
      chk("timeout time", 1, tcyc >= (k ? 2000 : 1500) && tcyc < (k ? 2300 : 1800));
      err_clr_in = 1;
      @(negedge clock_in);
      err_clr_in = 0;
      @(negedge clock_in);
      chk("cleared", 0, timeout_err_out);
    end
    end_sim();
  end
endmodule // testbench
`default_nettype wire

// ### verilog/sem_defs.svh
`ifndef SEM_DEFS_SVH
`define SEM_DEFS_SVH
`define SEM_SYS_HZ 100000000
`define SEM_LINK_HZ 66666666
`define SEM_LINK_NS 15
`define SEM_POS_W 48
`define SEM_ADD_W 16
`define SEM_RX_W 80
`define SEM_RING_N 10
`define SEM_RING_LAST 4'h9
`define SEM_RING_W 8
`define SEM_TX_BITS 7'h08
`define SEM_LEN_POS 7'h30
`define SEM_LEN_ONE 7'h40
`define SEM_LEN_TWO 7'h50
`define SEM_CMD_POS_OLD 6'h01
`define SEM_CMD_POS_NEW 6'h02
`define SEM_CMD_POS_ADD 6'h03
`define SEM_HZ_100K 100000
`define SEM_HZ_300K 300000
`define SEM_HZ_500K 500000
`define SEM_HZ_1M 1000000
`define SEM_HZ_2M 2000000
`define SEM_HZ_4M 4000000
`define SEM_HZ_5M 5000000
`define SEM_HZ_6M66 6666666
`define SEM_REC_LONG_NS 15000
`define SEM_REC_SHORT_NS 2000
`define SEM_REC_LONG_CYC ((`SEM_REC_LONG_NS + `SEM_LINK_NS - 1) / `SEM_LINK_NS)
`define SEM_REC_SHORT_CYC ((`SEM_REC_SHORT_NS + `SEM_LINK_NS - 1) / `SEM_LINK_NS)
`define SEM_CALC_LONG_US 1000
`define SEM_CALC_SHORT_US 15
`define SEM_CALC_LONG_CYC (`SEM_CALC_LONG_US * (`SEM_SYS_HZ / 1000000))
`define SEM_CALC_SHORT_CYC (`SEM_CALC_SHORT_US * (`SEM_SYS_HZ / 1000000))
`endif

// ### verilog/sem_master.sv
// Function
// - 48-bit position register updated per trigger
// - encoder clock from eight discrete frequency settings
// - default 300 kHz old, 2 MHz new
// - delay compensation switchable per axis
// - long or short recovery, long default
// - older encoder always uses long recovery
// - poll too long sets timeout status
// - calculation limit long or short, long reset
// - additional data only in three modes
// - none: plain position poll per trigger
// - fixed data; setting changes only while polling
// - variable: cycle through ten ring entries
// - variable: both data plus supplement each poll
// - snapshot command samples serial and incremental
// - incremental use forces older protocol commands
`timescale 1ns/1ps
`default_nettype none
`include "sem_defs.svh"
module sem_master import sem_pkg::*; #(
  parameter int unsigned CALC_LONG_CYC = `SEM_CALC_LONG_CYC
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic link_clk_in,
  input wire logic cfg_wr_in,
  input wire logic [22:0] cfg_freq_in,
  input wire logic cfg_newver_in,
  input wire logic cfg_delay_comp_in,
  input wire logic cfg_short_rec_in,
  input wire logic cfg_short_calc_in,
  input wire logic cfg_incr_in,
  input wire logic [1:0] op_mode_in,
  input wire logic [1:0] add_mode_in,
  input wire logic [1:0] fixed_sel_in,
  input wire logic ring_wr_in,
  input wire logic [3:0] ring_addr_in,
  input wire logic [7:0] ring_data_in,
  input wire logic trigger_in,
  input wire logic snap_cmd_in,
  input wire logic [31:0] inc_count_in,
  input wire logic err_clr_in,
  input wire logic enc_data_in,
  output logic [47:0] position_out,
  output logic [15:0] add1_out,
  output logic [15:0] add2_out,
  output logic pos_valid_out,
  output logic [47:0] snap_pos_out,
  output logic [31:0] snap_inc_out,
  output logic snap_done_out,
  output logic busy_out,
  output logic timeout_err_out,
  output logic cfg_reject_out,
  output logic enc_clk_out,
  output logic enc_data_out,
  output logic enc_data_oe_out
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [3:0] freq_dec(input logic [22:0] hz);
    case (hz)
      23'(`SEM_HZ_100K): freq_dec = {1'b1, SEM_F_100K};
      23'(`SEM_HZ_300K): freq_dec = {1'b1, SEM_F_300K};
      23'(`SEM_HZ_500K): freq_dec = {1'b1, SEM_F_500K};
      23'(`SEM_HZ_1M): freq_dec = {1'b1, SEM_F_1M};
      23'(`SEM_HZ_2M): freq_dec = {1'b1, SEM_F_2M};
      23'(`SEM_HZ_4M): freq_dec = {1'b1, SEM_F_4M};
      23'(`SEM_HZ_5M): freq_dec = {1'b1, SEM_F_5M};
      23'(`SEM_HZ_6M66): freq_dec = {1'b1, SEM_F_6M66};
      default: freq_dec = 4'h0;
    endcase
  endfunction

  // half period of the encoder clock in link clock cycles
  function automatic logic [8:0] half_of(input sem_freq_t f);
    case (f)
      SEM_F_100K: half_of = 9'(`SEM_LINK_HZ / (2 * `SEM_HZ_100K));
      SEM_F_300K: half_of = 9'(`SEM_LINK_HZ / (2 * `SEM_HZ_300K));
      SEM_F_500K: half_of = 9'(`SEM_LINK_HZ / (2 * `SEM_HZ_500K));
      SEM_F_1M: half_of = 9'(`SEM_LINK_HZ / (2 * `SEM_HZ_1M));
      SEM_F_2M: half_of = 9'(`SEM_LINK_HZ / (2 * `SEM_HZ_2M));
      SEM_F_4M: half_of = 9'(`SEM_LINK_HZ / (2 * `SEM_HZ_4M));
      SEM_F_5M: half_of = 9'(`SEM_LINK_HZ / (2 * `SEM_HZ_5M));
      default: half_of = 9'(`SEM_LINK_HZ / (2 * `SEM_HZ_6M66));
    endcase
  endfunction

  // ----------------------------------------
  // system domain
  // ----------------------------------------
  sem_ring_if rif ();
  sem_ring_mem u_ring (.clock_in(clock_in), .rstn_in(rstn_in), .rif(rif));

  sem_freq_t freq, next_freq;
  sem_add_t add_lat, next_add_lat, eff_add;
  logic newver, next_newver, dcomp, next_dcomp, short_rec, next_short_rec;
  logic short_calc, next_short_calc, incr, next_incr, next_reject;
  logic [1:0] fsel, next_fsel;
  logic busy, next_busy, start_tgl, next_start_tgl, abort_tgl, next_abort_tgl;
  logic [5:0] cmd, next_cmd;
  logic [6:0] rxlen, next_rxlen;
  logic supp_en, next_supp_en, snap_pend, next_snap_pend;
  logic [7:0] supp, next_supp;
  logic [3:0] ring_ptr, next_ring_ptr;
  logic [16:0] timer, next_timer, limit;
  logic [47:0] next_pos, next_snap_pos, pos_x;
  logic [15:0] next_add1, next_add2, add1_x, add2_x;
  logic [31:0] next_snap_inc;
  logic next_valid, next_snap_done, next_err, go, done_evt, tmo;
  logic [3:0] fd;
  logic done_s1, done_s2, done_s3, wait_s1, wait_s2;
  logic done_tgl, wait_lvl;
  logic [`SEM_RX_W-1:0] rx_sr;

  assign rif.wr_en = ring_wr_in;
  assign rif.wr_addr = ring_addr_in;
  assign rif.wr_data = ring_data_in;
  // read ahead so rd_data always matches the current pointer
  assign rif.rd_addr = next_ring_ptr;

  always_comb begin
    fd = freq_dec(cfg_freq_in);
    limit = short_calc ? 17'(`SEM_CALC_SHORT_CYC) : 17'(CALC_LONG_CYC);
    done_evt = done_s2 ^ done_s3;
    tmo = busy && wait_s2 && (timer == limit - 17'h1) && !done_evt;
    go = (trigger_in || snap_cmd_in) && !busy;
    // plain position only in polling, with older encoders or incremental use
    eff_add = (op_mode_in == SEM_OP_POLL || incr || !newver) ? SEM_ADD_NONE : add_lat;
    case (rxlen)
      `SEM_LEN_TWO: begin
        pos_x = rx_sr[79:32];
        add1_x = rx_sr[31:16];
        add2_x = rx_sr[15:0];
      end
      `SEM_LEN_ONE: begin
        pos_x = rx_sr[63:16];
        add1_x = fsel[0] ? rx_sr[15:0] : add1_out;
        add2_x = fsel[0] ? add2_out : rx_sr[15:0];
      end
      default: begin
        pos_x = rx_sr[47:0];
        add1_x = add1_out;
        add2_x = add2_out;
      end
    endcase
  end

  always_comb begin
    next_freq = freq;
    next_newver = newver;
    next_dcomp = dcomp;
    next_short_rec = short_rec;
    next_short_calc = short_calc;
    next_incr = incr;
    next_reject = cfg_reject_out;
    next_add_lat = add_lat;
    next_fsel = fsel;
    if (cfg_wr_in) begin
      next_reject = busy || (cfg_freq_in != 23'h0 && !fd[3]);
      if (!busy) begin
        next_newver = cfg_newver_in;
        next_dcomp = cfg_delay_comp_in;
        next_short_rec = cfg_short_rec_in && cfg_newver_in;
        next_short_calc = cfg_short_calc_in;
        next_incr = cfg_incr_in;
        if (cfg_freq_in == 23'h0) begin
          next_freq = cfg_newver_in ? SEM_F_2M : SEM_F_300K;
        end else if (fd[3]) begin
          next_freq = sem_freq_t'(fd[2:0]);
        end // else unchanged
      end
    end
    if (op_mode_in == SEM_OP_POLL) begin
      next_add_lat = sem_add_t'(add_mode_in);
      next_fsel = fixed_sel_in;
    end
  end

  always_comb begin
    next_busy = busy;
    next_start_tgl = start_tgl;
    next_abort_tgl = abort_tgl;
    next_cmd = cmd;
    next_rxlen = rxlen;
    next_supp_en = supp_en;
    next_supp = supp;
    next_snap_pend = snap_pend;
    next_ring_ptr = ring_ptr;
    next_timer = (busy && wait_s2) ? timer + 17'h1 : 17'h0;
    next_pos = position_out;
    next_add1 = add1_out;
    next_add2 = add2_out;
    next_snap_pos = snap_pos_out;
    next_snap_inc = snap_inc_out;
    next_valid = 1'b0;
    next_snap_done = 1'b0;
    next_err = (timeout_err_out && !err_clr_in) || tmo;
    if (go) begin
      next_busy = 1'b1;
      next_start_tgl = !start_tgl;
      next_snap_pend = snap_cmd_in;
      if (snap_cmd_in) begin
        next_snap_inc = inc_count_in;
      end
      next_supp_en = 1'b0;
      next_supp = rif.rd_data;
      case (eff_add)
        SEM_ADD_FIXED: begin
          next_cmd = (fsel == 2'h0) ? `SEM_CMD_POS_NEW : `SEM_CMD_POS_ADD;
          next_rxlen = (fsel == 2'h3) ? `SEM_LEN_TWO : (fsel == 2'h0) ? `SEM_LEN_POS : `SEM_LEN_ONE;
        end
        SEM_ADD_VAR: begin
          next_cmd = `SEM_CMD_POS_ADD;
          next_rxlen = `SEM_LEN_TWO;
          next_supp_en = 1'b1;
        end
        default: begin
          next_cmd = (incr || !newver) ? `SEM_CMD_POS_OLD : `SEM_CMD_POS_NEW;
          next_rxlen = `SEM_LEN_POS;
        end
      endcase
    end else if (busy && done_evt) begin
      next_busy = 1'b0;
      next_pos = pos_x;
      next_add1 = add1_x;
      next_add2 = add2_x;
      next_valid = 1'b1;
      if (snap_pend) begin
        next_snap_pos = pos_x;
        next_snap_done = 1'b1;
      end
      if (supp_en) begin
        next_ring_ptr = (ring_ptr == `SEM_RING_LAST) ? 4'h0 : ring_ptr + 4'h1;
      end
    end else if (tmo) begin
      // release the link from its wait; the encoder answer is dropped
      next_busy = 1'b0;
      next_abort_tgl = !abort_tgl;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      freq <= SEM_F_300K;
      newver <= 1'b0;
      dcomp <= 1'b0;
      short_rec <= 1'b0;
      short_calc <= 1'b0;
      incr <= 1'b0;
      cfg_reject_out <= 1'b0;
      add_lat <= SEM_ADD_NONE;
      fsel <= 2'h0;
      busy <= 1'b0;
      start_tgl <= 1'b0;
      abort_tgl <= 1'b0;
      cmd <= `SEM_CMD_POS_OLD;
      rxlen <= `SEM_LEN_POS;
      supp_en <= 1'b0;
      supp <= 8'h00;
      snap_pend <= 1'b0;
      ring_ptr <= 4'h0;
      timer <= 17'h0;
      position_out <= 48'h0;
      add1_out <= 16'h0;
      add2_out <= 16'h0;
      snap_pos_out <= 48'h0;
      snap_inc_out <= 32'h0;
      pos_valid_out <= 1'b0;
      snap_done_out <= 1'b0;
      timeout_err_out <= 1'b0;
      {done_s1, done_s2, done_s3, wait_s1, wait_s2} <= 5'h00;
    end else begin
      freq <= next_freq;
      newver <= next_newver;
      dcomp <= next_dcomp;
      short_rec <= next_short_rec;
      short_calc <= next_short_calc;
      incr <= next_incr;
      cfg_reject_out <= next_reject;
      add_lat <= next_add_lat;
      fsel <= next_fsel;
      busy <= next_busy;
      start_tgl <= next_start_tgl;
      abort_tgl <= next_abort_tgl;
      cmd <= next_cmd;
      rxlen <= next_rxlen;
      supp_en <= next_supp_en;
      supp <= next_supp;
      snap_pend <= next_snap_pend;
      ring_ptr <= next_ring_ptr;
      timer <= next_timer;
      position_out <= next_pos;
      add1_out <= next_add1;
      add2_out <= next_add2;
      snap_pos_out <= next_snap_pos;
      snap_inc_out <= next_snap_inc;
      pos_valid_out <= next_valid;
      snap_done_out <= next_snap_done;
      timeout_err_out <= next_err;
      {done_s1, done_s2, done_s3, wait_s1, wait_s2} <= {done_tgl, done_s1, done_s2, wait_lvl, wait_s1};
    end
  end
  assign busy_out = busy;

  // ----------------------------------------
  // link domain
  // ----------------------------------------
  // config regs are only written while idle, so they are stable when read here
  sem_lstate_t lstate, next_lstate;
  logic lrst_s1, lrstn, start_s1, start_s2, start_seen, abort_s1, abort_s2, abort_seen, din_s1, din_s2;
  logic [8:0] half_cnt, next_half, half_l, next_half_l;
  logic next_clk, next_dout, next_doe, dcomp_l, next_dcomp_l, supp_en_l, next_supp_en_l;
  logic [6:0] bit_cnt, next_bit, rxlen_l, next_rxlen_l;
  logic [7:0] tx_sr, next_tx;
  logic [`SEM_RX_W-1:0] next_rx;
  logic [9:0] rec_cnt, next_rec, rec_l, next_rec_l;
  logic next_done, next_sseen, active, tick, rise, fall, smp;

  always_comb begin
    next_lstate = lstate;
    next_half = half_cnt;
    next_half_l = half_l;
    next_clk = enc_clk_out;
    next_dout = enc_data_out;
    next_doe = enc_data_oe_out;
    next_bit = bit_cnt;
    next_tx = tx_sr;
    next_rx = rx_sr;
    next_rec = rec_cnt;
    next_rec_l = rec_l;
    next_rxlen_l = rxlen_l;
    next_dcomp_l = dcomp_l;
    next_supp_en_l = supp_en_l;
    next_done = done_tgl;
    next_sseen = start_seen;
    active = lstate != SEM_L_IDLE && lstate != SEM_L_RECOV;
    tick = half_cnt == 9'h0;
    if (active) begin
      next_half = tick ? half_l - 9'h1 : half_cnt - 9'h1;
      next_clk = tick ? !enc_clk_out : enc_clk_out;
    end
    rise = active && tick && !enc_clk_out;
    fall = active && tick && enc_clk_out;
    // with compensation the answer is taken half a period late
    smp = dcomp_l ? fall : rise;
    case (lstate)
      SEM_L_IDLE: begin
        if (start_s2 != start_seen) begin
          next_sseen = start_s2;
          next_lstate = SEM_L_CMD;
          next_half_l = half_of(freq);
          next_half = half_of(freq) - 9'h1;
          next_dcomp_l = dcomp;
          next_rxlen_l = rxlen;
          next_supp_en_l = supp_en;
          next_rec_l = short_rec ? 10'(`SEM_REC_SHORT_CYC) : 10'(`SEM_REC_LONG_CYC);
          next_tx = {2'b00, cmd};
          next_bit = `SEM_TX_BITS;
          next_rx = '0;
          next_doe = 1'b1;
        end
      end
      SEM_L_CMD, SEM_L_SUPP: begin
        if (fall) begin
          next_dout = tx_sr[7];
          next_tx = {tx_sr[6:0], 1'b0};
        end
        if (rise) begin
          next_bit = bit_cnt - 7'h1;
          if (bit_cnt == 7'h1) begin
            next_doe = 1'b0;
            if (lstate == SEM_L_CMD) begin
              next_lstate = SEM_L_WAIT;
            end else begin
              next_lstate = SEM_L_RECOV;
              next_rec = rec_l;
              next_done = !done_tgl;
            end
          end
        end
      end
      SEM_L_WAIT: begin
        if (abort_s2 != abort_seen) begin
          next_lstate = SEM_L_RECOV;
          next_rec = rec_l;
        end else if (smp && din_s2) begin
          next_lstate = SEM_L_RECV;
          next_bit = rxlen_l;
        end
      end
      SEM_L_RECV: begin
        if (smp) begin
          next_rx = {rx_sr[`SEM_RX_W-2:0], din_s2};
          next_bit = bit_cnt - 7'h1;
          if (bit_cnt == 7'h1) begin
            if (supp_en_l) begin
              next_lstate = SEM_L_SUPP;
              next_tx = supp;
              if (dcomp_l) begin
                // entered on a fall here, so the first bit goes out now
                next_dout = supp[7];
                next_tx = {supp[6:0], 1'b0};
              end
              next_bit = `SEM_TX_BITS;
              next_doe = 1'b1;
            end else begin
              next_lstate = SEM_L_RECOV;
              next_rec = rec_l;
              next_done = !done_tgl;
            end
          end
        end
      end
      SEM_L_RECOV: begin
        next_clk = 1'b1;
        next_doe = 1'b0;
        if (rec_cnt == 10'h0) begin
          next_lstate = SEM_L_IDLE;
        end else begin
          next_rec = rec_cnt - 10'h1;
        end
      end
      default: next_lstate = SEM_L_IDLE;
    endcase
  end

  always_ff @(posedge link_clk_in) begin
    lrst_s1 <= rstn_in;
    lrstn <= lrst_s1;
  end

  always_ff @(posedge link_clk_in) begin
    if (!lrstn) begin
      lstate <= SEM_L_IDLE;
      {start_s1, start_s2, start_seen, abort_s1, abort_s2, abort_seen, din_s1, din_s2} <= 8'h00;
      half_cnt <= 9'h0;
      half_l <= 9'h0;
      enc_clk_out <= 1'b1;
      enc_data_out <= 1'b0;
      enc_data_oe_out <= 1'b0;
      bit_cnt <= 7'h0;
      tx_sr <= 8'h00;
      rx_sr <= '0;
      rec_cnt <= 10'h0;
      rec_l <= 10'h0;
      rxlen_l <= `SEM_LEN_POS;
      dcomp_l <= 1'b0;
      supp_en_l <= 1'b0;
      done_tgl <= 1'b0;
      wait_lvl <= 1'b0;
    end else begin
      lstate <= next_lstate;
      {start_s1, start_s2, start_seen} <= {start_tgl, start_s1, next_sseen};
      {abort_s1, abort_s2, abort_seen} <= {abort_tgl, abort_s1, abort_s2};
      {din_s1, din_s2} <= {enc_data_in, din_s1};
      half_cnt <= next_half;
      half_l <= next_half_l;
      enc_clk_out <= next_clk;
      enc_data_out <= next_dout;
      enc_data_oe_out <= next_doe;
      bit_cnt <= next_bit;
      tx_sr <= next_tx;
      rx_sr <= next_rx;
      rec_cnt <= next_rec;
      rec_l <= next_rec_l;
      rxlen_l <= next_rxlen_l;
      dcomp_l <= next_dcomp_l;
      supp_en_l <= next_supp_en_l;
      done_tgl <= next_done;
      wait_lvl <= next_lstate == SEM_L_WAIT;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  reject_keep_a: assert property (cfg_wr_in && !busy && cfg_freq_in != 23'h0 && !fd[3]
    |=> cfg_reject_out && $stable(freq)) else $error("invalid frequency changed setting");
  dflt_freq_a: assert property (cfg_wr_in && !busy && cfg_freq_in == 23'h0
    |=> freq == ($past(cfg_newver_in) ? SEM_F_2M : SEM_F_300K)) else $error("wrong default frequency");
  old_rec_a: assert property (cfg_wr_in && !busy && !cfg_newver_in |=> !short_rec)
    else $error("short recovery with older encoder");
  calc_rst_a: assert property (disable iff (1'b0) !rstn_in |=> !short_calc)
    else $error("calculation limit not long after reset");
  timeout_flag_a: assert property (tmo |=> timeout_err_out && !busy ##1 timeout_err_out || $past(err_clr_in))
    else $error("timeout not flagged");
  fixed_lock_a: assert property (op_mode_in != SEM_OP_POLL |=> $stable(add_lat))
    else $error("additional data setting changed outside polling");
  poll_plain_a: assert property (go && op_mode_in == SEM_OP_POLL |=> rxlen == `SEM_LEN_POS && !supp_en)
    else $error("polling mode requested additional data");
  ring_wrap_a: assert property (busy && done_evt && supp_en && ring_ptr == `SEM_RING_LAST |=> ring_ptr == 4'h0)
    else $error("ring pointer did not wrap");
  snap_pair_a: assert property ((go && snap_cmd_in |=> snap_inc_out == $past(inc_count_in) && snap_pend)
    and (busy && done_evt && snap_pend |=> snap_done_out && snap_pos_out == position_out))
    else $error("snapshot pair broken");
  old_cmd_a: assert property (go && incr |=> cmd == `SEM_CMD_POS_OLD && rxlen == `SEM_LEN_POS)
    else $error("new command used with incremental signals");
  pos_upd_a: assert property (busy && done_evt |=> pos_valid_out && position_out == $past(pos_x))
    else $error("position not updated");
  rec_clk_a: assert property (@(posedge link_clk_in) disable iff (!lrstn)
    lstate == SEM_L_RECOV |=> enc_clk_out && !enc_data_oe_out) else $error("clock not idle in recovery");
  tmo_cov: cover property (tmo);
  snap_cov: cover property (snap_done_out);
  var_cov: cover property (busy && done_evt && supp_en && ring_ptr == `SEM_RING_LAST);
endmodule // sem_master
`default_nettype wire

// ### verilog/sem_pkg.sv
package sem_pkg;
  typedef enum logic [2:0] {
    SEM_F_100K, SEM_F_300K, SEM_F_500K, SEM_F_1M, SEM_F_2M, SEM_F_4M, SEM_F_5M, SEM_F_6M66
  } sem_freq_t;
  typedef enum logic [1:0] {SEM_OP_POLL, SEM_OP_SOFTRT, SEM_OP_STREAM, SEM_OP_RECORD} sem_op_t;
  typedef enum logic [1:0] {SEM_ADD_NONE, SEM_ADD_FIXED, SEM_ADD_VAR, SEM_ADD_RSVD} sem_add_t;
  typedef enum logic [2:0] {
    SEM_L_IDLE = 3'h0, SEM_L_CMD = 3'h1, SEM_L_WAIT = 3'h3,
    SEM_L_RECV = 3'h2, SEM_L_SUPP = 3'h6, SEM_L_RECOV = 3'h4
  } sem_lstate_t;
endpackage

// ### verilog/sem_ring_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sem_ring_if;
  logic wr_en;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  logic [3:0] rd_addr;
  logic [7:0] rd_data;
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
  modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface
`default_nettype wire

// ### verilog/sem_ring_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "sem_defs.svh"
module sem_ring_mem (
  input wire logic clock_in,
  input wire logic rstn_in,
  sem_ring_if.mem rif
);
  logic [`SEM_RING_W-1:0] mem [`SEM_RING_N];
  logic [`SEM_RING_W-1:0] rd_q;

  // entries hold data only, so they carry no reset
  always_ff @(posedge clock_in) begin
    if (rif.wr_en && rif.wr_addr <= `SEM_RING_LAST) begin
      mem[rif.wr_addr] <= rif.wr_data;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= (rif.rd_addr <= `SEM_RING_LAST) ? mem[rif.rd_addr] : 8'h00;
    end
  end
  assign rif.rd_data = rd_q;
endmodule // sem_ring_mem
`default_nettype wire
